// *** design/pps_device.sv ***
`timescale 1ns/10ps
`include "pps_defs.svh"
module pps_device
   import pps_pkg::*;
(
   input logic CLOCK,
   input logic RESET,
   pps_bus_if.dev BUS,
   input logic MST_REQ,
   input logic [31:0] MST_ADDR,
   input logic [3:0] MST_CMD,
   input logic [3:0] MST_BE,
   input logic [31:0] MST_WDATA,
   input logic MST_POSTED,
   output logic MST_DONE,
   output logic MST_MABORT,
   output logic MST_TABORT,
   output logic MST_RETRY,
   output logic [31:0] MST_RDATA,
   input logic TGT_DECODE_HIT,
   input logic TGT_RETRY,
   input logic [31:0] TGT_RDATA,
   output logic TGT_VALID,
   output logic [31:0] TGT_ADDR,
   output logic [3:0] TGT_CMD,
   output logic [31:0] TGT_WDATA,
   output logic [3:0] TGT_BE,
   input logic POSTED_PERR,
   input logic SECONDARY_SYSTEM_ERR_N,
   input logic POSTED_DISCARD,
   input logic DLY_WR_DISCARD,
   input logic DLY_RD_DISCARD,
   input logic DLY_MST_TIMEOUT,
   output logic LINK_66MHZ,
   output logic BUS_LOCKED
);
   pps_dev_t s, next_s;
   logic frame_n, irdy_n, trdy_n, devsel_n, stop_n, gnt, bus_idle, addr_phase;
   logic mst_wr, cfg_cmd, hit, addr_err, park;

   assign frame_n = BUS.primary_frame_n;
   assign irdy_n = BUS.primary_initiator_ready_n;
   assign trdy_n = BUS.primary_target_ready_n;
   assign devsel_n = BUS.primary_device_claim_n;
   assign stop_n = BUS.primary_stop_n;
   assign gnt = ~BUS.primary_grant_n;
   assign bus_idle = frame_n & irdy_n;
   // first clock of frame low after an idle bus is the address phase
   assign addr_phase = ~frame_n & s.frame_q & s.irdy_q;
   // command must stay steady while the request is up
   assign mst_wr = MST_CMD[`PPS_CMD_WR_BIT];
   assign cfg_cmd = (BUS.primary_cmd_byte_en == `PPS_CMD_CFG_RD) ||
      (BUS.primary_cmd_byte_en == `PPS_CMD_CFG_WR);
   assign hit = cfg_cmd ? (BUS.primary_config_select &&
      BUS.primary_ad[1:0] == `PPS_CFG_TYPE0) : TGT_DECODE_HIT;

   always_comb
   begin
      next_s = s;
      addr_err = 1'h0;
      park = 1'h0;
      next_s.mst_done = 1'h0;
      next_s.mst_mabort = 1'h0;
      next_s.mst_tabort = 1'h0;
      next_s.mst_retry = 1'h0;
      next_s.tgt_valid = 1'h0;
      next_s.frame_q = frame_n;
      next_s.irdy_q = irdy_n;
      next_s.speed66 = BUS.primary_speed_select;
      next_s.locked = ~BUS.primary_lock_n;
      next_s.req_oe = 1'h1;

      // bus request with enforced release gap
      if (s.req && !(MST_REQ && s.mst == MS_IDLE))
      begin
         next_s.req = 1'h0;
         next_s.gap = `PPS_REQ_GAP;
      end
      else if (!s.req && s.gap != 2'h0)
         next_s.gap = s.gap - 2'h1;
      else if (!s.req && MST_REQ && s.mst == MS_IDLE)
         next_s.req = 1'h1;

      // parity of the word seen one clock earlier
      if (addr_phase)
      begin
         next_s.chk_addr = 1'h1;
         next_s.cap_ad = BUS.primary_ad;
         next_s.cap_cbe = BUS.primary_cmd_byte_en;
      end
      if (s.chk_addr)
      begin
         next_s.chk_addr = 1'h0;
         addr_err = BUS.primary_parity != pps_parity(s.cap_ad, s.cap_cbe);
      end
      if (s.perr_ph == `PPS_PERR_DRIVE)
         next_s.perr_ph = `PPS_PERR_RELEASE;
      else
         next_s.perr_ph = `PPS_PERR_OFF;
      if (s.chk_data)
      begin
         next_s.chk_data = 1'h0;
         if (BUS.primary_parity != pps_parity(s.cap_ad, s.cap_cbe))
            next_s.perr_ph = `PPS_PERR_DRIVE;
      end

      case (s.mst)
         MS_IDLE:
         begin
            if (MST_REQ && gnt && bus_idle && s.tgt == TS_IDLE)
            begin
               next_s.mst = MS_ADDR;
               next_s.drv.ad = MST_ADDR;
               next_s.drv.cbe = MST_CMD;
            end
         end
         MS_ADDR:
         begin
            next_s.mst = MS_DATA;
            next_s.drv.ad = MST_WDATA;
            next_s.drv.cbe = MST_BE;
            next_s.wait_cnt = 3'h1;
            next_s.dev_seen = 1'h0;
         end
         MS_DATA:
         begin
            next_s.wait_cnt = s.wait_cnt + 3'h1;
            if (!devsel_n)
               next_s.dev_seen = 1'h1;
            if (!devsel_n && (!trdy_n || !stop_n))
            begin
               next_s.mst = MS_END;
               next_s.mst_done = 1'h1;
               next_s.mst_retry = trdy_n;
               if (!trdy_n && !mst_wr)
               begin
                  next_s.mst_rdata = BUS.primary_ad;
                  next_s.cap_ad = BUS.primary_ad;
                  next_s.cap_cbe = BUS.primary_cmd_byte_en;
                  next_s.chk_data = 1'h1;
               end
            end
            else if (s.dev_seen && !stop_n)
            begin
               next_s.mst = MS_END;
               next_s.mst_done = 1'h1;
               next_s.mst_tabort = 1'h1;
            end
            else if (!s.dev_seen && devsel_n && s.wait_cnt == `PPS_DEVSEL_WAIT)
            begin
               next_s.mst = MS_END;
               next_s.mst_done = 1'h1;
               next_s.mst_mabort = 1'h1;
            end
         end
         MS_END:
            next_s.mst = MS_IDLE;
         default:
            next_s.mst = MS_IDLE;
      endcase

      case (s.tgt)
         TS_IDLE:
         begin
            if (addr_phase && s.mst == MS_IDLE && hit)
            begin
               next_s.tgt = TS_CLAIM;
               next_s.tgt_addr = BUS.primary_ad;
               next_s.tgt_cmd = BUS.primary_cmd_byte_en;
               next_s.tgt_wr = BUS.primary_cmd_byte_en[`PPS_CMD_WR_BIT];
            end
         end
         TS_CLAIM:
         begin
            next_s.tgt = TGT_RETRY ? TS_STOP : TS_DATA;
            next_s.drv.ad = TGT_RDATA;
         end
         TS_DATA:
         begin
            if (!irdy_n)
            begin
               next_s.tgt_valid = 1'h1;
               next_s.tgt_be = BUS.primary_cmd_byte_en;
               next_s.tgt_wdata = BUS.primary_ad;
               next_s.cap_ad = BUS.primary_ad;
               next_s.cap_cbe = BUS.primary_cmd_byte_en;
               next_s.chk_data = s.tgt_wr;
               // one word per access; a burst is cut with a disconnect
               next_s.tgt = frame_n ? TS_END : TS_STOP;
            end
         end
         TS_STOP:
         begin
            if (frame_n)
               next_s.tgt = TS_END;
         end
         TS_END:
            next_s.tgt = TS_IDLE;
         default:
            next_s.tgt = TS_IDLE;
      endcase

      next_s.serr = addr_err | POSTED_PERR | ~SECONDARY_SYSTEM_ERR_N |
         (MST_POSTED & (next_s.mst_mabort | next_s.mst_tabort));
      next_s.serr = next_s.serr | POSTED_DISCARD | DLY_WR_DISCARD |
         DLY_RD_DISCARD | DLY_MST_TIMEOUT;

      park = next_s.mst == MS_IDLE && next_s.tgt == TS_IDLE && gnt && bus_idle;
      next_s.drv.frame_oe = next_s.mst == MS_ADDR || next_s.mst == MS_DATA;
      next_s.drv.frame_n = next_s.mst != MS_ADDR;
      next_s.drv.irdy_oe = next_s.mst == MS_DATA || next_s.mst == MS_END;
      next_s.drv.irdy_n = next_s.mst != MS_DATA;
      next_s.drv.ad_oe = next_s.mst == MS_ADDR || (next_s.mst == MS_DATA && mst_wr) ||
         (next_s.tgt == TS_DATA && !next_s.tgt_wr) || park;
      next_s.drv.cbe_oe = next_s.mst == MS_ADDR || next_s.mst == MS_DATA || park;
      next_s.drv.par = pps_parity(BUS.primary_ad, BUS.primary_cmd_byte_en);
      next_s.drv.par_oe = s.drv.ad_oe;
      next_s.drv.trdy_oe = next_s.tgt != TS_IDLE;
      next_s.drv.trdy_n = next_s.tgt != TS_DATA;
      next_s.drv.devsel_oe = next_s.tgt != TS_IDLE;
      next_s.drv.devsel_n = next_s.tgt == TS_END;
      next_s.drv.stop_oe = next_s.tgt != TS_IDLE;
      next_s.drv.stop_n = next_s.tgt != TS_STOP;
   end

   // async clear drops every enable at once, no clock needed
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
         s <= '0;
      else
         s <= next_s;
   end

   assign BUS.dev_drv = s.drv;
   assign BUS.dev_perr_n = s.perr_ph != `PPS_PERR_DRIVE;
   assign BUS.dev_perr_oe = s.perr_ph != `PPS_PERR_OFF;
   assign BUS.dev_serr_oe = s.serr;
   assign BUS.dev_req_n = ~s.req;
   assign BUS.dev_req_oe = s.req_oe;
   assign MST_DONE = s.mst_done;
   assign MST_MABORT = s.mst_mabort;
   assign MST_TABORT = s.mst_tabort;
   assign MST_RETRY = s.mst_retry;
   assign MST_RDATA = s.mst_rdata;
   assign TGT_VALID = s.tgt_valid;
   assign TGT_ADDR = s.tgt_addr;
   assign TGT_CMD = s.tgt_cmd;
   assign TGT_WDATA = s.tgt_wdata;
   assign TGT_BE = s.tgt_be;
   assign LINK_66MHZ = s.speed66;
   assign BUS_LOCKED = s.locked;
endmodule // pps_device

// *** design/pps_host.sv ***
`timescale 1ns/10ps
`include "pps_defs.svh"
module pps_host
   import pps_pkg::*;
(
   input logic CLOCK,
   input logic RESET,
   pps_bus_if.host BUS,
   input logic H_REQ,
   input logic [31:0] H_ADDR,
   input logic [3:0] H_CMD,
   input logic [3:0] H_BE,
   input logic [31:0] H_WDATA,
   input logic H_IDSEL,
   input logic H_LOCK,
   input logic H_PARK_DEV,
   input logic H_SPEED_66,
   output logic H_DONE,
   output logic H_MABORT,
   output logic H_TABORT,
   output logic H_RETRY,
   output logic [31:0] H_RDATA,
   input logic H_TGT_EN,
   input logic H_TGT_RETRY,
   input logic [31:0] H_TGT_RDATA,
   output logic H_TGT_VALID,
   output logic [31:0] H_TGT_ADDR,
   output logic [31:0] H_TGT_WDATA
);
   pps_host_t s, next_s;
   logic frame_n, irdy_n, trdy_n, devsel_n, stop_n, bus_idle, wr;

   assign frame_n = BUS.primary_frame_n;
   assign irdy_n = BUS.primary_initiator_ready_n;
   assign trdy_n = BUS.primary_target_ready_n;
   assign devsel_n = BUS.primary_device_claim_n;
   assign stop_n = BUS.primary_stop_n;
   assign bus_idle = frame_n & irdy_n;
   assign wr = H_CMD[`PPS_CMD_WR_BIT];

   always_comb
   begin
      next_s = s;
      next_s.done = 1'h0;
      next_s.mabort = 1'h0;
      next_s.tabort = 1'h0;
      next_s.retry = 1'h0;
      next_s.tgt_valid = 1'h0;
      next_s.frame_q = frame_n;
      next_s.irdy_q = irdy_n;
      next_s.speed66 = H_SPEED_66;
      // host wins; grant must be low two clocks before the host starts
      next_s.gnt = !H_REQ && s.mst == MS_IDLE && (!BUS.primary_req_n || H_PARK_DEV);
      next_s.gnt_q = s.gnt;
      next_s.lock = H_LOCK;
      next_s.lock_oe = H_LOCK || s.lock;

      case (s.mst)
         MS_IDLE:
         begin
            if (H_REQ && !s.gnt && !s.gnt_q && bus_idle && s.tgt == TS_IDLE)
            begin
               next_s.mst = MS_ADDR;
               next_s.drv.ad = H_ADDR;
               next_s.drv.cbe = H_CMD;
            end
         end
         MS_ADDR:
         begin
            next_s.mst = MS_DATA;
            next_s.drv.ad = H_WDATA;
            next_s.drv.cbe = H_BE;
            next_s.wait_cnt = 3'h1;
            next_s.dev_seen = 1'h0;
         end
         MS_DATA:
         begin
            next_s.wait_cnt = s.wait_cnt + 3'h1;
            if (!devsel_n)
               next_s.dev_seen = 1'h1;
            if (!devsel_n && (!trdy_n || !stop_n))
            begin
               next_s.mst = MS_END;
               next_s.done = 1'h1;
               next_s.retry = trdy_n;
               if (!trdy_n)
                  next_s.rdata = BUS.primary_ad;
            end
            else if ((s.dev_seen && !stop_n) ||
               (!s.dev_seen && devsel_n && s.wait_cnt == `PPS_DEVSEL_WAIT))
            begin
               next_s.mst = MS_END;
               next_s.done = 1'h1;
               next_s.tabort = s.dev_seen;
               next_s.mabort = !s.dev_seen;
            end
         end
         MS_END:
            next_s.mst = MS_IDLE;
         default:
            next_s.mst = MS_IDLE;
      endcase

      case (s.tgt)
         TS_IDLE:
         begin
            if (!frame_n && s.frame_q && s.irdy_q && s.mst == MS_IDLE && H_TGT_EN)
            begin
               next_s.tgt = TS_CLAIM;
               next_s.tgt_addr = BUS.primary_ad;
               next_s.tgt_wr = BUS.primary_cmd_byte_en[`PPS_CMD_WR_BIT];
            end
         end
         TS_CLAIM:
         begin
            next_s.tgt = H_TGT_RETRY ? TS_STOP : TS_DATA;
            next_s.drv.ad = H_TGT_RDATA;
         end
         TS_DATA:
         begin
            if (!irdy_n)
            begin
               next_s.tgt_valid = 1'h1;
               next_s.tgt_wdata = BUS.primary_ad;
               next_s.tgt = frame_n ? TS_END : TS_STOP;
            end
         end
         TS_STOP:
         begin
            if (frame_n)
               next_s.tgt = TS_END;
         end
         TS_END:
            next_s.tgt = TS_IDLE;
         default:
            next_s.tgt = TS_IDLE;
      endcase

      next_s.cfg_sel = next_s.mst == MS_ADDR && H_IDSEL;
      next_s.drv.frame_oe = next_s.mst == MS_ADDR || next_s.mst == MS_DATA;
      next_s.drv.frame_n = next_s.mst != MS_ADDR;
      next_s.drv.irdy_oe = next_s.mst == MS_DATA || next_s.mst == MS_END;
      next_s.drv.irdy_n = next_s.mst != MS_DATA;
      next_s.drv.ad_oe = next_s.mst == MS_ADDR || (next_s.mst == MS_DATA && wr) ||
         (next_s.tgt == TS_DATA && !next_s.tgt_wr);
      next_s.drv.cbe_oe = next_s.mst == MS_ADDR || next_s.mst == MS_DATA;
      next_s.drv.par = pps_parity(BUS.primary_ad, BUS.primary_cmd_byte_en);
      next_s.drv.par_oe = s.drv.ad_oe;
      next_s.drv.trdy_oe = next_s.tgt != TS_IDLE;
      next_s.drv.trdy_n = next_s.tgt != TS_DATA;
      next_s.drv.devsel_oe = next_s.tgt != TS_IDLE;
      next_s.drv.devsel_n = next_s.tgt == TS_END;
      next_s.drv.stop_oe = next_s.tgt != TS_IDLE;
      next_s.drv.stop_n = next_s.tgt != TS_STOP;
   end

   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
         s <= '0;
      else
         s <= next_s;
   end

   assign BUS.host_drv = s.drv;
   assign BUS.host_lock_n = ~s.lock;
   assign BUS.host_lock_oe = s.lock_oe;
   assign BUS.host_gnt_n = ~s.gnt;
   assign BUS.host_cfg_sel = s.cfg_sel;
   assign BUS.host_speed = s.speed66;
   assign H_DONE = s.done;
   assign H_MABORT = s.mabort;
   assign H_TABORT = s.tabort;
   assign H_RETRY = s.retry;
   assign H_RDATA = s.rdata;
   assign H_TGT_VALID = s.tgt_valid;
   assign H_TGT_ADDR = s.tgt_addr;
   assign H_TGT_WDATA = s.tgt_wdata;
endmodule // pps_host

// *** inc/pps_bus_if.sv ***
`timescale 1ns/10ps
`include "pps_defs.svh"
interface pps_bus_if;
   import pps_pkg::*;
   pps_drv_t dev_drv, host_drv;
   logic dev_perr_n, dev_perr_oe, dev_serr_oe, dev_req_n, dev_req_oe;
   logic host_lock_n, host_lock_oe, host_gnt_n, host_cfg_sel, host_speed;
   logic [31:0] primary_ad;
   logic [3:0] primary_cmd_byte_en;
   logic primary_parity, primary_frame_n, primary_initiator_ready_n, primary_target_ready_n;
   logic primary_device_claim_n, primary_stop_n, primary_lock_n, primary_data_parity_err_n;
   logic primary_system_err_n, primary_req_n, primary_grant_n, primary_config_select;
   logic primary_speed_select;
   // undriven lines float high through the board pull-ups
   assign primary_ad = dev_drv.ad_oe ? dev_drv.ad : host_drv.ad_oe ? host_drv.ad : `PPS_PULL_AD;
   assign primary_cmd_byte_en = dev_drv.cbe_oe ? dev_drv.cbe :
      host_drv.cbe_oe ? host_drv.cbe : `PPS_PULL_CBE;
   assign primary_parity = dev_drv.par_oe ? dev_drv.par : host_drv.par_oe ? host_drv.par : 1'h1;
   assign primary_frame_n = dev_drv.frame_oe ? dev_drv.frame_n :
      host_drv.frame_oe ? host_drv.frame_n : 1'h1;
   assign primary_initiator_ready_n = dev_drv.irdy_oe ? dev_drv.irdy_n :
      host_drv.irdy_oe ? host_drv.irdy_n : 1'h1;
   assign primary_target_ready_n = dev_drv.trdy_oe ? dev_drv.trdy_n :
      host_drv.trdy_oe ? host_drv.trdy_n : 1'h1;
   assign primary_device_claim_n = dev_drv.devsel_oe ? dev_drv.devsel_n :
      host_drv.devsel_oe ? host_drv.devsel_n : 1'h1;
   assign primary_stop_n = dev_drv.stop_oe ? dev_drv.stop_n :
      host_drv.stop_oe ? host_drv.stop_n : 1'h1;
   assign primary_lock_n = host_lock_oe ? host_lock_n : 1'h1;
   assign primary_data_parity_err_n = dev_perr_oe ? dev_perr_n : 1'h1;
   assign primary_system_err_n = ~dev_serr_oe;
   assign primary_req_n = dev_req_oe ? dev_req_n : 1'h1;
   assign primary_grant_n = host_gnt_n;
   assign primary_config_select = host_cfg_sel;
   assign primary_speed_select = host_speed;
   modport dev (
      output dev_drv, dev_perr_n, dev_perr_oe, dev_serr_oe, dev_req_n, dev_req_oe,
      input primary_ad, primary_cmd_byte_en, primary_parity, primary_frame_n,
      input primary_initiator_ready_n, primary_target_ready_n, primary_device_claim_n,
      input primary_stop_n, primary_lock_n, primary_grant_n, primary_config_select,
      input primary_speed_select
   );
   modport host (
      output host_drv, host_lock_n, host_lock_oe, host_gnt_n, host_cfg_sel, host_speed,
      input primary_ad, primary_cmd_byte_en, primary_frame_n, primary_initiator_ready_n,
      input primary_target_ready_n, primary_device_claim_n, primary_stop_n, primary_req_n
   );
endinterface

// *** inc/pps_defs.svh ***
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_DEVSEL_WAIT 3'h5
`define PPS_REQ_GAP 2'h2
`define PPS_CMD_CFG_RD 4'hA
`define PPS_CMD_CFG_WR 4'hB
`define PPS_CMD_WR_BIT 0
`define PPS_CFG_TYPE0 2'h0
`define PPS_PULL_AD 32'hFFFF_FFFF
`define PPS_PULL_CBE 4'hF
`define PPS_PERR_OFF 2'h0
`define PPS_PERR_DRIVE 2'h1
`define PPS_PERR_RELEASE 2'h2
`endif

// *** inc/pps_pkg.sv ***
package pps_pkg;
   typedef enum logic [1:0] {MS_IDLE, MS_ADDR, MS_DATA, MS_END} pps_mst_t;
   typedef enum logic [2:0] {TS_IDLE, TS_CLAIM, TS_DATA, TS_STOP, TS_END} pps_tgt_t;
   typedef struct packed {
      logic [31:0] ad;
      logic ad_oe;
      logic [3:0] cbe;
      logic cbe_oe;
      logic par, par_oe, frame_n, frame_oe, irdy_n, irdy_oe;
      logic trdy_n, trdy_oe, devsel_n, devsel_oe, stop_n, stop_oe;
   } pps_drv_t;
   typedef struct packed {
      pps_mst_t mst;
      pps_tgt_t tgt;
      pps_drv_t drv;
      logic [2:0] wait_cnt;
      logic dev_seen, req, req_oe;
      logic [1:0] gap;
      logic tgt_wr, frame_q, irdy_q, chk_data, chk_addr, serr;
      logic [31:0] cap_ad;
      logic [3:0] cap_cbe;
      logic [1:0] perr_ph;
      logic mst_done, mst_mabort, mst_tabort, mst_retry;
      logic [31:0] mst_rdata;
      logic tgt_valid;
      logic [31:0] tgt_addr, tgt_wdata;
      logic [3:0] tgt_cmd, tgt_be;
      logic speed66, locked;
   } pps_dev_t;
   typedef struct packed {
      pps_mst_t mst;
      pps_tgt_t tgt;
      pps_drv_t drv;
      logic [2:0] wait_cnt;
      logic dev_seen, gnt, gnt_q, lock, lock_oe, cfg_sel, speed66;
      logic tgt_wr, frame_q, irdy_q;
      logic done, mabort, tabort, retry, tgt_valid;
      logic [31:0] rdata, tgt_addr, tgt_wdata;
   } pps_host_t;
   function automatic logic pps_parity(input logic [31:0] ad, input logic [3:0] cbe);
      return ^{ad, cbe};
   endfunction
endpackage

// *** verification/pps_asserts.sv ***
`timescale 1ns/10ps
`include "pps_defs.svh"
module pps_asserts
   import pps_pkg::*;
(
   input logic CLOCK,
   input logic RESET,
   input pps_drv_t dev_drv,
   input pps_drv_t host_drv,
   input logic host_lock_n,
   input logic host_lock_oe,
   input logic primary_req_n,
   input logic primary_grant_n,
   input logic primary_config_select,
   input logic primary_initiator_ready_n,
   input logic primary_target_ready_n,
   input logic primary_stop_n,
   input logic [31:0] primary_ad,
   input logic [3:0] primary_cmd_byte_en
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RESET);
   wire dev_go = dev_drv.frame_oe && !dev_drv.frame_n;
   wire host_go = host_drv.frame_oe && !host_drv.frame_n;
   wire cfg_cmd = primary_cmd_byte_en[3:1] == 3'h5;
   wire dev_claim = dev_drv.devsel_oe && !dev_drv.devsel_n;
   a_req_gap_min: assert property ($rose(primary_req_n) |-> primary_req_n [*2])
      else $error("request gap too short");
   a_start_on_grant: assert property ($rose(dev_go) |-> !$past(primary_grant_n))
      else $error("access started without grant");
   a_master_ends: assert property ($rose(dev_go) |-> ##[2:10] !dev_drv.irdy_oe)
      else $error("master access never ended");
   a_trdy_release: assert property ($fell(dev_drv.trdy_oe) |-> $past(dev_drv.trdy_n))
      else $error("target ready floated while low");
   a_devsel_release: assert property ($fell(dev_drv.devsel_oe) |-> $past(dev_drv.devsel_n))
      else $error("claim floated while low");
   a_lock_release: assert property ($fell(host_lock_oe) |-> $past(host_lock_n))
      else $error("lock floated while low");
   a_trdy_holds: assert property (dev_drv.trdy_oe && !dev_drv.trdy_n && primary_initiator_ready_n
      |=> dev_drv.trdy_oe && !dev_drv.trdy_n) else $error("target ready dropped early");
   a_irdy_holds: assert property (dev_drv.irdy_oe && !dev_drv.irdy_n && primary_target_ready_n
      && primary_stop_n && host_drv.devsel_oe && !host_drv.devsel_n |=> !dev_drv.irdy_n)
      else $error("initiator ready dropped early");
   a_parity_even: assert property (dev_drv.par_oe && $past(dev_drv.ad_oe)
      |-> !(^{$past(primary_ad), $past(primary_cmd_byte_en), dev_drv.par}))
      else $error("odd parity driven");
   a_cfg_claim: assert property ($rose(host_go) && primary_config_select && cfg_cmd
      && primary_ad[1:0] == 2'h0 |=> dev_claim) else $error("config access not claimed");
   a_cfg_ignore: assert property ($rose(host_go) && !primary_config_select && cfg_cmd
      |=> !dev_claim [*4]) else $error("unselected config claimed");
   cover property ($rose(dev_go));
   cover property (dev_claim);
   cover property ($fell(host_lock_oe));
endmodule // pps_asserts

// *** verification/pps_bench.sv ***
`timescale 1ns/10ps
`include "pps_defs.svh"
module pps_bench;
   logic CLOCK = 1'h0, RESET = 1'h1, MST_REQ = 1'h0, MST_POSTED = 1'h0, TGT_DECODE_HIT = 1'h0;
   logic TGT_RETRY = 1'h0, SECONDARY_SYSTEM_ERR_N = 1'h1, H_REQ = 1'h0, H_IDSEL = 1'h0;
   logic H_LOCK = 1'h0, H_PARK_DEV = 1'h0, H_SPEED_66 = 1'h0, H_TGT_EN = 1'h0, H_TGT_RETRY = 1'h0;
   logic [3:0] MST_CMD = 4'h0, H_CMD = 4'h0, TGT_CMD, TGT_BE;
   logic [4:0] err_ev = 5'h00;
   logic [31:0] MST_ADDR = 32'h0000_0000, MST_WDATA = 32'h0000_0000, TGT_RDATA = 32'h0000_0000;
   logic [31:0] H_ADDR = 32'h0000_0000, H_WDATA = 32'h0000_0000, H_TGT_RDATA = 32'h0000_0000;
   logic MST_DONE, MST_MABORT, MST_TABORT, MST_RETRY, TGT_VALID, LINK_66MHZ, BUS_LOCKED;
   logic H_DONE, H_MABORT, H_TABORT, H_RETRY, H_TGT_VALID, ewr, dn, ab, rt, req_seen, serr_seen;
   logic [31:0] MST_RDATA, TGT_ADDR, TGT_WDATA, H_RDATA, H_TGT_ADDR, H_TGT_WDATA, ea, ed, r;
   logic [31:0] seed = 32'h0000_FDA7;
   logic [3:0] cmds [4] = '{`PPS_CMD_CFG_RD, `PPS_CMD_CFG_WR, 4'h6, 4'h7};
   int mismatches = 0, total_checks = 0, words, i;
   pps_bus_if bus_if ();
   pps_device pps_device_inst (.CLOCK, .RESET, .BUS(bus_if), .MST_REQ, .MST_ADDR, .MST_CMD,
      .MST_BE(4'hF), .MST_WDATA, .MST_POSTED, .MST_DONE, .MST_MABORT, .MST_TABORT, .MST_RETRY,
      .MST_RDATA, .TGT_DECODE_HIT, .TGT_RETRY, .TGT_RDATA, .TGT_VALID, .TGT_ADDR, .TGT_CMD,
      .TGT_WDATA, .TGT_BE, .POSTED_PERR(err_ev[4]), .SECONDARY_SYSTEM_ERR_N,
      .POSTED_DISCARD(err_ev[3]), .DLY_WR_DISCARD(err_ev[2]), .DLY_RD_DISCARD(err_ev[1]),
      .DLY_MST_TIMEOUT(err_ev[0]), .LINK_66MHZ, .BUS_LOCKED);
   pps_host pps_host_inst (.CLOCK, .RESET, .BUS(bus_if), .H_REQ, .H_ADDR, .H_CMD, .H_BE(4'hF),
      .H_WDATA, .H_IDSEL, .H_LOCK, .H_PARK_DEV, .H_SPEED_66, .H_DONE, .H_MABORT, .H_TABORT,
      .H_RETRY, .H_RDATA, .H_TGT_EN, .H_TGT_RETRY, .H_TGT_RDATA, .H_TGT_VALID, .H_TGT_ADDR,
      .H_TGT_WDATA);
   pps_asserts pps_asserts_inst (.CLOCK, .RESET, .dev_drv(bus_if.dev_drv),
      .host_drv(bus_if.host_drv), .host_lock_n(bus_if.host_lock_n),
      .host_lock_oe(bus_if.host_lock_oe), .primary_req_n(bus_if.primary_req_n),
      .primary_grant_n(bus_if.primary_grant_n), .primary_ad(bus_if.primary_ad),
      .primary_config_select(bus_if.primary_config_select),
      .primary_initiator_ready_n(bus_if.primary_initiator_ready_n),
      .primary_target_ready_n(bus_if.primary_target_ready_n),
      .primary_stop_n(bus_if.primary_stop_n), .primary_cmd_byte_en(bus_if.primary_cmd_byte_en));
   always #10 CLOCK = ~CLOCK;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // only type 0 config with word-aligned address is claimed on select
   function automatic logic exp_claim(input logic [31:0] a, input logic [3:0] c, input logic sel, hit);
      if (c == `PPS_CMD_CFG_RD || c == `PPS_CMD_CFG_WR)
         return sel && a[1:0] == `PPS_CFG_TYPE0;
      return hit;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (mismatches == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // word strobes may trail the done pulse, so every tick watches them
   task automatic tick();
      @(posedge CLOCK);
      #2;
      req_seen |= !bus_if.primary_req_n;
      serr_seen |= !bus_if.primary_system_err_n | !bus_if.primary_data_parity_err_n;
      if (TGT_VALID | H_TGT_VALID)
      begin
         words++;
         if (TGT_VALID)
            chk(TGT_BE, 4'hF);
         chk(TGT_VALID ? TGT_ADDR : H_TGT_ADDR, ea);
         if (ewr)
            chk(TGT_VALID ? TGT_WDATA : H_TGT_WDATA, ed);
      end
   endtask
   task automatic wait_end(input logic host);
      {dn, words, req_seen, serr_seen} = 0;
      for (int n = 0; n < 40 && !dn; n++)
      begin
         tick();
         {dn, ab, rt} = host ? {H_DONE, H_MABORT | H_TABORT, H_RETRY} :
            {MST_DONE, MST_MABORT | MST_TABORT, MST_RETRY};
      end
      chk(dn, 1'h1);
      H_REQ = 1'h0;
      MST_REQ = 1'h0;
      repeat (4) tick();
   endtask
   task automatic host_acc(input logic [31:0] a, input logic [3:0] c, input logic sel, hit, rty);
      logic claim;
      claim = exp_claim(a, c, sel, hit);
      ed = rnd();
      {ea, ewr, H_ADDR, H_CMD, H_IDSEL, TGT_DECODE_HIT, TGT_RETRY} = {a, c[0], a, c, sel, hit, rty};
      {H_WDATA, TGT_RDATA} = {ed, ~ed};
      H_REQ = 1'h1;
      wait_end(1'h1);
      chk(ab, !claim);
      chk(rt, claim & rty);
      chk(words, claim & !rty);
      chk(serr_seen, 1'h0);
      if (claim)
         chk(TGT_CMD, c);
      if (claim & !rty & !c[0])
         chk(H_RDATA, ~ed);
   endtask
   task automatic dev_acc(input logic [3:0] c, input logic en, rty, post);
      {ea, ed} = {rnd(), rnd()};
      {MST_ADDR, MST_CMD, MST_WDATA, H_TGT_RDATA, ewr} = {ea, c, ed, ~ed, c[0]};
      {H_TGT_EN, H_TGT_RETRY, MST_POSTED} = {en, rty, post};
      MST_REQ = 1'h1;
      wait_end(1'h0);
      chk(req_seen, 1'h1);
      chk(ab, !en);
      chk(rt, en & rty);
      chk(words, en & !rty);
      chk(serr_seen, post & !en);
      if (en & !rty & !c[0])
         chk(MST_RDATA, ~ed);
   endtask
   initial
   begin
      repeat (12) @(posedge CLOCK);
      #2;
      RESET = 1'h0;
      repeat (3) tick();
      host_acc(32'h0000_0010, `PPS_CMD_CFG_WR, 1'h1, 1'h0, 1'h0);
      host_acc(32'h0000_0014, `PPS_CMD_CFG_RD, 1'h1, 1'h0, 1'h0);
      host_acc(32'h0000_0011, `PPS_CMD_CFG_WR, 1'h1, 1'h1, 1'h0);
      host_acc(32'h0000_0010, `PPS_CMD_CFG_RD, 1'h0, 1'h1, 1'h0);
      host_acc(32'h0000_0020, 4'h7, 1'h0, 1'h1, 1'h1);
      dev_acc(4'h7, 1'h0, 1'h0, 1'h1);
      for (i = 0; i < 40; i++)
      begin
         r = rnd();
         host_acc({r[31:2], r[5:4] & {2{r[6]}}}, cmds[r[1:0]], r[2], r[3], r[7] & r[8]);
         r = rnd();
         dev_acc({3'h3, r[0]}, r[1] | r[2], r[3] & r[4], r[0] & r[5]);
      end
      for (i = 0; i < 6; i++)
      begin
         err_ev = 5'h10 >> i;
         SECONDARY_SYSTEM_ERR_N = i != 5;
         tick();
         chk(bus_if.primary_system_err_n, 1'h0);
         {err_ev, SECONDARY_SYSTEM_ERR_N} = 6'h01;
         tick();
         chk(bus_if.primary_system_err_n, 1'h1);
      end
      for (i = 1; i >= 0; i--)
      begin
         {H_LOCK, H_SPEED_66} = {2{i[0]}};
         repeat (3) tick();
         chk(BUS_LOCKED, i[0]);
         chk(LINK_66MHZ, i[0]);
      end
      H_PARK_DEV = 1'h1;
      repeat (4) tick();
      chk({bus_if.dev_drv.ad_oe, bus_if.dev_drv.cbe_oe, bus_if.dev_drv.par_oe}, 3'h7);
      RESET = 1'h1;
      #1;
      chk({bus_if.dev_drv.ad_oe, bus_if.dev_drv.par_oe, bus_if.dev_req_oe}, 3'h0);
      H_PARK_DEV = 1'h0;
      repeat (2) tick();
      RESET = 1'h0;
      repeat (4) tick();
      chk(bus_if.dev_drv.ad_oe, 1'h0);
      host_acc(32'h0000_0010, `PPS_CMD_CFG_WR, 1'h1, 1'h0, 1'h0);
      finish_test();
   end
   initial
   begin
      repeat (5000) @(posedge CLOCK);
      mismatches++;
      finish_test();
   end
endmodule // pps_bench
